//--- dma_ext_request_single_addr.sv
module dma_ext_request_single_addr (
  input  wire logic        ref_clk,
  input  wire logic        resetn,
  input  wire logic        ce,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  output logic      [31:0] reg_rdata,
  input  wire logic        transfer_request_n,
  output logic             transfer_ack_n,
  input  wire logic        done_in_n,
  output logic             done_out_n,
  output logic             done_oe,
  output logic             bus_req,
  input  wire logic        bus_grant,
  output logic             bus_strobe,
  output logic             bus_read,
  output logic      [31:0] bus_addr,
  output logic      [3:0]  bus_fc,
  output logic      [1:0]  bus_size,
  input  wire logic        bus_term
);
  logic [1:0]  rst_sync_reg;
  logic        rst_n;
  logic [11:0] control_reg;
  logic [31:0] source_pointer_reg;
  logic [31:0] destination_pointer_reg;
  logic [7:0]  function_code_select_reg;
  logic [31:0] count_reg;
  logic        done_flag_reg;
  logic        cfg_err_reg;
  logic [31:0] rdata_reg;
  dma_req_pkg::chan_state_type state_reg, state_next;
  logic        ack_n_reg, ack_n_next;
  logic        strobe_reg, bus_req_reg, read_reg;
  logic [31:0] addr_reg;
  logic [3:0]  fc_reg;
  logic [1:0]  size_reg;
  logic        done_drive_reg;
  logic        pend_reg;
  logic        burst_cont_reg;
  logic        last_seen_reg;
  logic        external, steal, single, side, present, cfg_bad, last_op, go_on;
  logic [1:0]  ssize, dsize;
  logic [31:0] op_bytes;
  logic        acked_cycle;

  pin_sync_if req_if ();
  pin_sync_if done_if ();
  assign req_if.pin_n  = transfer_request_n;
  assign done_if.pin_n = done_in_n;

  pin_filter req_filter (.ref_clk(ref_clk), .rst_n(rst_n), .ce(ce), .sig(req_if));
  pin_filter done_filter (.ref_clk(ref_clk), .rst_n(rst_n), .ce(ce), .sig(done_if));

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      rst_sync_reg <= 2'h0;
    else
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
  end
  assign rst_n = rst_sync_reg[1];

  function automatic logic [31:0] size_bytes(input logic [1:0] code);
    case (code)
      dma_req_pkg::SIZE_BYTE: size_bytes = dma_req_pkg::BYTES_1;
      dma_req_pkg::SIZE_WORD: size_bytes = dma_req_pkg::BYTES_2;
      default:                size_bytes = dma_req_pkg::BYTES_4;
    endcase
  endfunction

  assign external = control_reg[dma_req_pkg::CTL_EXTERNAL];
  assign steal    = control_reg[dma_req_pkg::CTL_CYCLE_STEAL];
  assign single   = control_reg[dma_req_pkg::CTL_SINGLE];
  assign side     = control_reg[dma_req_pkg::CTL_SIDE];
  assign ssize    = control_reg[dma_req_pkg::CTL_SSIZE_LO +: 2];
  assign dsize    = control_reg[dma_req_pkg::CTL_DSIZE_LO +: 2];
  // single read counts source operands, everything else destination operands
  assign op_bytes = size_bytes((single && side) ? ssize : dsize);
  // internal single or dual long is refused
  assign cfg_bad  = (single && !external) ||
                    (!single && (ssize == dma_req_pkg::SIZE_LONG ||
                                 dsize == dma_req_pkg::SIZE_LONG));
  // level in burst, recognised edge in cycle steal
  assign present  = steal ? pend_reg : req_if.level;
  assign last_op  = (count_reg <= op_bytes) || last_seen_reg;
  // continue without release while request stands
  assign go_on    = control_reg[dma_req_pkg::CTL_START] &&
                    (!external || (steal ? pend_reg : burst_cont_reg));
  // handshake belongs to the requesting side only
  assign acked_cycle = external &&
                       ((state_next == dma_req_pkg::ST_SRC && (side || !single) && side) ||
                        (state_next == dma_req_pkg::ST_DST && !side));

  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      dma_req_pkg::ST_IDLE:
        // no bus request before a request in external mode
        if (control_reg[dma_req_pkg::CTL_START] && !cfg_bad && (!external || present))
          state_next = dma_req_pkg::ST_ARB;
      dma_req_pkg::ST_ARB:
        if (bus_grant)
          // single is one cycle, read or write by side
          state_next = (single && !side) ? dma_req_pkg::ST_DST : dma_req_pkg::ST_SRC;
      dma_req_pkg::ST_SRC:
        if (bus_term)
          state_next = single ? dma_req_pkg::ST_GAP : dma_req_pkg::ST_TURN;
      dma_req_pkg::ST_TURN:
        state_next = dma_req_pkg::ST_DST;
      dma_req_pkg::ST_DST:
        if (bus_term)
          state_next = dma_req_pkg::ST_GAP;
      dma_req_pkg::ST_GAP:
        if (!last_op && go_on)
          state_next = (single && !side) ? dma_req_pkg::ST_DST : dma_req_pkg::ST_SRC;
        else
          // release bus when no request stands
          state_next = dma_req_pkg::ST_IDLE;
      default:
        state_next = dma_req_pkg::ST_IDLE;
    endcase
  end

  // ack dropped at every cycle end
  assign ack_n_next = !(acked_cycle && (state_next != state_reg ||
                                        state_reg == dma_req_pkg::ST_SRC ||
                                        state_reg == dma_req_pkg::ST_DST) &&
                        !((state_reg == dma_req_pkg::ST_SRC ||
                           state_reg == dma_req_pkg::ST_DST) && bus_term));

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      state_reg <= dma_req_pkg::ST_IDLE;
    else if (ce)
      state_reg <= state_next;
  end

  // bus cycle drive; strobe stays low for the gap cycle between cycles
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ack_n_reg      <= 1'b1;
      strobe_reg     <= 1'b0;
      bus_req_reg    <= 1'b0;
      read_reg       <= 1'b1;
      addr_reg       <= 32'h0000_0000;
      fc_reg         <= 4'h0;
      size_reg       <= 2'h0;
      done_drive_reg <= 1'b0;
    end
    else if (ce)
    begin
      ack_n_reg   <= ack_n_next;
      bus_req_reg <= state_next != dma_req_pkg::ST_IDLE;
      strobe_reg  <= (state_next == dma_req_pkg::ST_SRC || state_next == dma_req_pkg::ST_DST)
                     && !((state_reg == dma_req_pkg::ST_SRC ||
                           state_reg == dma_req_pkg::ST_DST) && bus_term);
      // done driven in the acked last cycle, external mode only
      done_drive_reg <= !ack_n_next && last_op;
      if (state_next == dma_req_pkg::ST_SRC)
      begin
        read_reg <= 1'b1;
        addr_reg <= source_pointer_reg;
        fc_reg   <= function_code_select_reg[dma_req_pkg::FC_SRC_LO +: 4];
        size_reg <= ssize;
      end
      else if (state_next == dma_req_pkg::ST_DST)
      begin
        read_reg <= 1'b0;
        addr_reg <= destination_pointer_reg;
        fc_reg   <= function_code_select_reg[dma_req_pkg::FC_DST_LO +: 4];
        size_reg <= dsize;
      end
    end
  end

  // request bookkeeping
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pend_reg       <= 1'b0;
      burst_cont_reg <= 1'b0;
      last_seen_reg  <= 1'b0;
    end
    else if (ce)
    begin
      // pulse kept when none pending or during ack; set wins
      if (req_if.fall && (!pend_reg || !ack_n_reg))
        pend_reg <= 1'b1;
      else if (ack_n_reg && !ack_n_next)
        pend_reg <= 1'b0;
      // burst continues only if request seen while ack asserted
      if (!ack_n_reg && req_if.level)
        burst_cont_reg <= 1'b1;
      else if (ack_n_reg && !ack_n_next)
        burst_cont_reg <= 1'b0;
      // peripheral marks last transfer during a bus cycle
      if (bus_strobe && done_if.level)
        last_seen_reg <= 1'b1;
      else if (state_reg == dma_req_pkg::ST_IDLE)
        last_seen_reg <= 1'b0;
    end
  end

  // register file; hardware completion beats software on start and flags
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      control_reg              <= dma_req_pkg::CONTROL_RESET;
      source_pointer_reg       <= 32'h0000_0000;
      destination_pointer_reg  <= 32'h0000_0000;
      function_code_select_reg <= 8'h00;
      count_reg                <= 32'h0000_0000;
      done_flag_reg            <= 1'b0;
      cfg_err_reg              <= 1'b0;
    end
    else if (ce)
    begin
      if (reg_write)
        case (reg_addr)
          dma_req_pkg::OFF_CONTROL: control_reg <= reg_wdata[11:0];
          dma_req_pkg::OFF_SRC_PTR: source_pointer_reg <= reg_wdata;
          dma_req_pkg::OFF_DST_PTR: destination_pointer_reg <= reg_wdata;
          dma_req_pkg::OFF_FC_SEL:  function_code_select_reg <= reg_wdata[7:0];
          dma_req_pkg::OFF_COUNT:   count_reg <= reg_wdata;
          dma_req_pkg::OFF_STATUS:
          begin
            if (reg_wdata[dma_req_pkg::ST_DONE])
              done_flag_reg <= 1'b0;
            if (reg_wdata[dma_req_pkg::ST_CFG_ERR])
              cfg_err_reg <= 1'b0;
          end
          default: ;
        endcase
      if (state_reg == dma_req_pkg::ST_IDLE && control_reg[dma_req_pkg::CTL_START] && cfg_bad)
      begin
        cfg_err_reg <= 1'b1;
        control_reg[dma_req_pkg::CTL_START] <= 1'b0;
      end
      if (state_reg == dma_req_pkg::ST_SRC && bus_term &&
          control_reg[dma_req_pkg::CTL_SRC_INC])
        source_pointer_reg <= 32'(source_pointer_reg + size_bytes(ssize));
      if (state_reg == dma_req_pkg::ST_DST && bus_term &&
          control_reg[dma_req_pkg::CTL_DST_INC])
        destination_pointer_reg <= 32'(destination_pointer_reg + size_bytes(dsize));
      if (state_reg == dma_req_pkg::ST_GAP)
      begin
        count_reg <= last_op ? 32'h0000_0000 : 32'(count_reg - op_bytes);
        if (last_op)
        begin
          done_flag_reg <= 1'b1;
          control_reg[dma_req_pkg::CTL_START] <= 1'b0;
        end
      end
    end
  end

  // read data stands one cycle after the strobe only
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      rdata_reg <= 32'h0000_0000;
    else if (ce)
    begin
      rdata_reg <= 32'h0000_0000;
      if (reg_read)
        case (reg_addr)
          dma_req_pkg::OFF_CONTROL: rdata_reg <= {20'h00000, control_reg};
          dma_req_pkg::OFF_SRC_PTR: rdata_reg <= source_pointer_reg;
          dma_req_pkg::OFF_DST_PTR: rdata_reg <= destination_pointer_reg;
          dma_req_pkg::OFF_FC_SEL:  rdata_reg <= {24'h000000, function_code_select_reg};
          dma_req_pkg::OFF_COUNT:   rdata_reg <= count_reg;
          dma_req_pkg::OFF_STATUS:
            rdata_reg <= {28'h0000000, bus_req_reg, cfg_err_reg, done_flag_reg,
                          state_reg != dma_req_pkg::ST_IDLE};
          default: rdata_reg <= 32'h0000_0000;
        endcase
    end
  end

  assign reg_rdata      = rdata_reg;
  assign transfer_ack_n = ack_n_reg;
  assign done_oe        = done_drive_reg;
  assign done_out_n     = ~done_drive_reg;
  assign bus_req        = bus_req_reg;
  assign bus_strobe     = strobe_reg;
  assign bus_read       = read_reg;
  assign bus_addr       = addr_reg;
  assign bus_fc         = fc_reg;
  assign bus_size       = size_reg;

  a_wait_for_request: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (ce && state_reg == dma_req_pkg::ST_IDLE && state_next == dma_req_pkg::ST_ARB)
    |-> (control_reg[dma_req_pkg::CTL_START] && (!external || present)))
    else $error("bus requested without start and request");
  a_ack_side_only: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !ack_n_reg |-> (external && ((state_reg == dma_req_pkg::ST_SRC && side) ||
                                 (state_reg == dma_req_pkg::ST_DST && !side))))
    else $error("acknowledge outside requesting cycle");
  a_ack_drops_at_end: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (ce && !ack_n_reg && bus_term) |-> ack_n_next)
    else $error("acknowledge not negated at cycle end");
  a_src_cycle_read: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (strobe_reg && state_reg == dma_req_pkg::ST_SRC)
    |-> (read_reg && size_reg == ssize && addr_reg == source_pointer_reg))
    else $error("source cycle not a read");
  a_dst_cycle_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (strobe_reg && state_reg == dma_req_pkg::ST_DST)
    |-> (!read_reg && size_reg == dsize && addr_reg == destination_pointer_reg))
    else $error("destination cycle not a write");
  a_single_external: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (ce && state_reg == dma_req_pkg::ST_IDLE && state_next == dma_req_pkg::ST_ARB)
    |-> !(single && !external))
    else $error("single address started internally");
  a_burst_release: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (ce && state_reg == dma_req_pkg::ST_GAP && external && !steal && !burst_cont_reg)
    |-> state_next == dma_req_pkg::ST_IDLE)
    else $error("burst kept bus without request");
  a_steal_release: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (ce && state_reg == dma_req_pkg::ST_GAP && external && steal && !pend_reg)
    |-> state_next == dma_req_pkg::ST_IDLE)
    else $error("cycle steal kept bus without pulse");
  a_dual_order: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (ce && !single && state_reg == dma_req_pkg::ST_SRC && bus_term)
    |-> state_next == dma_req_pkg::ST_TURN)
    else $error("dual read not followed by write");
  a_no_long_dual: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (strobe_reg && !single) |-> size_reg != dma_req_pkg::SIZE_LONG)
    else $error("long operand in dual address");
endmodule // dma_ext_request_single_addr

//--- dma_req_pkg.sv
package dma_req_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_CONTROL  = 8'h00;
  localparam logic [7:0] OFF_SRC_PTR  = 8'h04;
  localparam logic [7:0] OFF_DST_PTR  = 8'h08;
  localparam logic [7:0] OFF_FC_SEL   = 8'h0C;
  localparam logic [7:0] OFF_COUNT    = 8'h10;
  localparam logic [7:0] OFF_STATUS   = 8'h14;
  // channel_control fields
  localparam int CTL_START       = 0;
  localparam int CTL_EXTERNAL    = 1;
  localparam int CTL_CYCLE_STEAL = 2;
  localparam int CTL_SINGLE      = 3;
  localparam int CTL_SIDE        = 4;
  localparam int CTL_SRC_INC     = 5;
  localparam int CTL_DST_INC     = 6;
  localparam int CTL_SSIZE_LO    = 8;
  localparam int CTL_DSIZE_LO    = 10;
  localparam logic [11:0] CONTROL_RESET = 12'h000;
  // function_code_select fields
  localparam int FC_SRC_LO = 0;
  localparam int FC_DST_LO = 4;
  // status fields
  localparam int ST_BUSY      = 0;
  localparam int ST_DONE      = 1;
  localparam int ST_CFG_ERR   = 2;
  localparam int ST_BUS_OWNED = 3;
  // operand size codes
  localparam logic [1:0] SIZE_LONG = 2'h0;
  localparam logic [1:0] SIZE_BYTE = 2'h1;
  localparam logic [1:0] SIZE_WORD = 2'h2;
  localparam logic [31:0] BYTES_1 = 32'h0000_0001;
  localparam logic [31:0] BYTES_2 = 32'h0000_0002;
  localparam logic [31:0] BYTES_4 = 32'h0000_0004;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ARB  = 3'b001,
    ST_SRC  = 3'b010,
    ST_TURN = 3'b011,
    ST_DST  = 3'b100,
    ST_GAP  = 3'b101
  } chan_state_type;
endpackage

//--- pin_sync_if.sv
interface pin_sync_if;
  logic pin_n;
  logic level;
  logic fall;
  modport filter (input pin_n, output level, output fall);
  modport user (output pin_n, input level, input fall);
endinterface

//--- pin_filter.sv
module pin_filter (
  input  wire logic    ref_clk,
  input  wire logic    rst_n,
  input  wire logic    ce,
  pin_sync_if.filter   sig
);
  logic [2:0] sync_reg;
  logic       level_reg;
  logic       fall_reg;

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      sync_reg <= 3'h7;
    else if (ce)
      sync_reg <= {sync_reg[1:0], sig.pin_n};
  end

  // asserted once seen low on two consecutive samples
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      level_reg <= 1'b0;
      fall_reg  <= 1'b0;
    end
    else if (ce)
    begin
      fall_reg <= 1'b0;
      if (sync_reg[1] == sync_reg[2])
      begin
        level_reg <= ~sync_reg[2];
        fall_reg  <= ~sync_reg[2] & ~level_reg;
      end
    end
  end

  assign sig.level = level_reg;
  assign sig.fall  = fall_reg;
endmodule // pin_filter

//--- req_peripheral.sv
module req_peripheral (
  input  wire logic       ref_clk,
  input  wire logic       transfer_ack_n,
  input  wire logic       go,
  input  wire logic       steal,
  input  wire logic       extra,
  input  wire logic [7:0] want,
  output logic            transfer_request_n,
  output logic            done_in_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] left = 8'h00;
  logic [3:0] t = 4'hF;
  logic [1:0] pc = 2'h0;
  logic       ack_d = 1'b1;
  logic       pulse_n = 1'b1;
  wire  logic fall = ack_d & ~transfer_ack_n;
  // done pin pulled up; this peer never ends a block early
  // off-chip peer, so single-address service is allowed here
  assign done_in_n = 1'b1;
  // level held through every ack but the last wanted one
  // a lone transfer gets a short level, gone before its ack
  assign transfer_request_n = steal ? pulse_n : !((t < 4'h6) || (left > 8'h01));
  always @(posedge ref_clk)
  begin
    ack_d <= transfer_ack_n;
    // pulses last exactly two clocks, the shortest allowed
    pulse_n <= (pc == 2'h0);
    if (go)
      left <= want;
    else if (fall && left != 8'h00)
      left <= left - 8'h01;
    t <= go ? 4'h0 : ((t == 4'hF) ? t : t + 4'h1);
    // next pulse while ack low; one stray pulse before ack
    if (go || (fall && left > 8'h01) || (extra && t == 4'h3))
      pc <= 2'h2;
    else if (pc != 2'h0)
      pc <= pc - 2'h1;
  end
endmodule // req_peripheral

//--- dma_ext_request_single_addr_tb_top.sv
module dma_ext_request_single_addr_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk = 1'b0;
  logic        resetn = 1'b0;
  logic        ce = 1'b1;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_write = 1'b0;
  logic        reg_read = 1'b0;
  logic [31:0] reg_rdata;
  logic        req_n;
  logic        ack_n;
  logic        done_in_n;
  logic        done_out_n;
  logic        done_oe;
  logic        bus_req;
  logic        bus_grant = 1'b0;
  logic        bus_strobe;
  logic        bus_read;
  logic [31:0] bus_addr;
  logic [3:0]  bus_fc;
  logic [1:0]  bus_size;
  logic        bus_term = 1'b0;
  logic        go = 1'b0;
  logic        steal = 1'b0;
  logic        extra = 1'b0;
  logic [7:0]  want = 8'h00;
  logic [5:0]  req_sr = 6'h00;
  logic [2:0]  wcnt = 3'h2;
  logic        term_d = 1'b0;
  logic [41:0] ent[$];
  integer      seed = 32'h1fb7;
  integer      mismatches = 0;
  integer      checks = 0;
  always #5 ref_clk = ~ref_clk;
  dma_ext_request_single_addr dut_u (.ref_clk(ref_clk), .resetn(resetn), .ce(ce),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata), .transfer_request_n(req_n),
    .transfer_ack_n(ack_n), .done_in_n(done_in_n), .done_out_n(done_out_n),
    .done_oe(done_oe), .bus_req(bus_req), .bus_grant(bus_grant),
    .bus_strobe(bus_strobe), .bus_read(bus_read), .bus_addr(bus_addr),
    .bus_fc(bus_fc), .bus_size(bus_size), .bus_term(bus_term));
  req_peripheral peer_u (.ref_clk(ref_clk), .transfer_ack_n(ack_n), .go(go),
    .steal(steal), .extra(extra), .want(want), .transfer_request_n(req_n),
    .done_in_n(done_in_n));
  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // slow grant keeps stray pulses well ahead of the ack
  always @(posedge ref_clk)
  begin
    req_sr <= {req_sr[4:0], bus_req};
    bus_grant <= req_sr[5] & bus_req;
    term_d <= bus_strobe & bus_term;
    if (bus_strobe & ~bus_term)
    begin
      if (wcnt == 3'h0)
        bus_term <= 1'b1;
      else
        wcnt <= wcnt - 3'h1;
    end
    else
    begin
      bus_term <= 1'b0;
      // at least three wait states: request drop must clear the pin sync in time
      wcnt <= 3'(3 + ($random(seed) & 3));
    end
    if (bus_strobe & bus_term)
      ent.push_back({ack_n, done_out_n, done_oe, bus_read, bus_fc, bus_size, bus_addr});
    if (term_d)
      check("ack_after_cycle", ack_n, 1);
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_read <= 1'b0;
    @(posedge ref_clk);
    d = reg_rdata;
  endtask
  task automatic idle_check(input string what);
    repeat (12)
    begin
      @(posedge ref_clk);
      check(what, bus_req, 0);
    end
  endtask
  task automatic run(input logic single, input logic side, input logic stl,
                     input logic [1:0] sz, input logic [7:0] n, input logic [7:0] ww);
    logic [31:0] src;
    logic [31:0] dst;
    logic [31:0] bytes;
    logic [31:0] st;
    logic [7:0]  fc;
    logic [41:0] e;
    logic        isrd;
    logic        ackd;
    logic        last;
    int          per;
    int          idx;
    bytes = (sz == dma_req_pkg::SIZE_BYTE) ? dma_req_pkg::BYTES_1 :
            (sz == dma_req_pkg::SIZE_WORD) ? dma_req_pkg::BYTES_2 : dma_req_pkg::BYTES_4;
    src = $random(seed) & 32'hFFFF_FFF0;
    dst = $random(seed) & 32'hFFFF_FFF0;
    fc = 8'($random(seed));
    per = single ? 1 : 2;
    ent.delete();
    wr(dma_req_pkg::OFF_SRC_PTR, src);
    wr(dma_req_pkg::OFF_DST_PTR, dst);
    wr(dma_req_pkg::OFF_FC_SEL, {24'h0, fc});
    wr(dma_req_pkg::OFF_COUNT, 32'(n) * bytes);
    // sizes, both increments, side, single, steal, external, start
    wr(dma_req_pkg::OFF_CONTROL, {20'h0, sz, sz, 3'b011, side, single, stl, 2'b11});
    idle_check("bus_req_before_request");
    steal <= stl;
    extra <= stl;
    want <= ww;
    go <= 1'b1;
    @(posedge ref_clk);
    go <= 1'b0;
    for (int i = 0; i < 4000 && ent.size() < ww * per; i++)
      @(posedge ref_clk);
    repeat (30) @(posedge ref_clk);
    check("cycle_count", ent.size(), ww * per);
    check("bus_released", bus_req, 0);
    foreach (ent[k])
    begin
      idx = k / per;
      isrd = single ? side : (k % per == 0);
      ackd = single || (isrd == side);
      last = ackd && (idx == n - 1);
      e = ent[k];
      check("bus_cycle", e, {~ackd, ~last, last, isrd, isrd ? fc[3:0] : fc[7:4], sz,
            (isrd ? src : dst) + 32'(idx) * bytes});
    end
    if (n == ww)
    begin
      rd(dma_req_pkg::OFF_STATUS, st);
      check("status_done", st[1:0], 2'b10);
      wr(dma_req_pkg::OFF_STATUS, 32'h2);
    end
    else
      wr(dma_req_pkg::OFF_CONTROL, 32'h0);
  endtask
  initial
  begin
    #1_000_000;
    mismatches++;
    report_and_stop();
  end
  initial
  begin : main
    logic [31:0] d;
    logic [7:0]  n;
    logic [1:0]  sz;
    repeat (6) @(posedge ref_clk);
    resetn <= 1'b1;
    repeat (4) @(posedge ref_clk);
    check("reset_outputs", {ack_n, done_out_n, done_oe, bus_req, bus_strobe}, 5'b11000);
    rd(dma_req_pkg::OFF_STATUS, d);
    check("status_reset", d, 0);
    rd(8'hF0, d);
    check("unmapped_read", d, 0);
    ce <= 1'b0;
    wr(dma_req_pkg::OFF_COUNT, 32'h5A5A_0001);
    ce <= 1'b1;
    rd(dma_req_pkg::OFF_COUNT, d);
    check("count_frozen", d, 0);
    $display("test reset done, mismatches %0d", mismatches);
    for (int m = 0; m < 16; m++)
    begin
      sz = (m[0]) ? 2'($unsigned($random(seed)) % 3) : dma_req_pkg::SIZE_BYTE;
      n = 8'(1 + $unsigned($random(seed)) % 4);
      run(m[0], m[1], m[2], sz, n, n);
      $display("test mode %0d done, mismatches %0d", m, mismatches);
    end
    // burst peer gives up after one transfer of three
    run(1'b1, 1'b0, 1'b0, dma_req_pkg::SIZE_WORD, 8'h3, 8'h1);
    $display("test burst drop done, mismatches %0d", mismatches);
    for (int j = 0; j < 2; j++)
    begin
      wr(dma_req_pkg::OFF_CONTROL, j == 0 ? 32'h9 : 32'h3);
      idle_check("bus_req_bad_config");
      rd(dma_req_pkg::OFF_STATUS, d);
      check("config_error", d[2], 1);
      rd(dma_req_pkg::OFF_CONTROL, d);
      check("start_cleared", d[0], 0);
      wr(dma_req_pkg::OFF_STATUS, 32'h4);
    end
    $display("test config error done, mismatches %0d", mismatches);
    report_and_stop();
  end
endmodule // dma_ext_request_single_addr_tb_top
